// File: rtl/nmt_node.sv
// node-state machine, service gating, heartbeat, boot-up, sync and emergency framing
// assumes a CAN controller that delivers received frames as one-cycle strobes and
// accepts transmit frames over a valid/ready handshake on the same clock
//
// Contract
// - power-up enters init, then pre-operational automatically
// - command frame id 0; byte1 address, 0 broadcast
// - 01 to operational, 02 to stopped
// - 80 pre-operational, 81 app reset, 82 comm reset
// - no acknowledgement frame for state commands
// - init, then app reset, then comm reset
// - pdo only operational; commands outside init
// - sdo sync time emcy only preop/operational
// - heartbeat sent every configured producer period
// - missing consumer heartbeat within timeout flags fault
// - one boot-up frame on entering pre-operational; sent here only after comm reset, not on command 80
// - synchronous mode defers commands to next sync
// - fault sends emergency; clear sends code 0
// - emergency id 80h+node, code, errreg, maker bytes
// - error register 0 none, 1 generic, 80 internal
// - identifiers 11 bits, function code plus address
// - broadcast ids fixed: 0, 80h, 100h
// - emcy 81h, tpdo 181h.., rpdo 201h.. bases
// - sdo 581h/601h, heartbeat and boot-up 701h
`timescale 1ns/1ps
`default_nettype none
`include "nmt_node_regs.svh"

module nmt_node
  import nmt_node_pkg::*;
#(
  parameter int HB_W = 16
)
(
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic [6:0]       node_addr,
  input  wire logic             rx_valid,
  input  wire can_frame_t       rx_frame,
  output logic                  tx_valid,
  input  wire logic             tx_ready,
  output can_frame_t            tx_frame,
  input  wire logic [HB_W-1:0]  hb_period,
  input  wire logic [HB_W-1:0]  hb_timeout,
  input  wire logic [6:0]       hb_producer_addr,
  output logic                  hb_fault,
  input  wire logic             sync_mode,
  output logic                  sync_pulse,
  output logic                  time_pulse,
  output logic                  pdo_enable,
  output logic                  sdo_enable,
  input  wire logic             fault_active,
  input  wire logic [15:0]      fault_code,
  input  wire logic             fault_internal,
  input  wire logic [39:0]      fault_maker,
  output logic [7:0]            error_reg,
  output logic                  error_state,
  output node_state_t           node_state,
  output logic                  app_reset_pulse
);

  logic        rst_s1_q;
  logic        rst_n_q;
  node_state_t state_q;
  logic [15:0] step_cnt_q;
  logic        boot_pend_q;
  logic        cmd_pend_q;
  logic [7:0]  cmd_cs_q;
  logic [HB_W-1:0] hb_cnt_q;
  logic        hb_pend_q;
  logic [HB_W-1:0] cons_cnt_q;
  logic        hb_seen_q;
  logic        fault_s1_q;
  logic        fault_q;
  logic        emcy_pend_q;
  logic        emcy_clear_q;
  logic        hb_fault_q;
  logic        err_q;
  logic [7:0]  err_reg_q;
  logic [15:0] emcy_code_q;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      {rst_s1_q, rst_n_q} <= 2'b00;
    else
      {rst_s1_q, rst_n_q} <= {1'b1, rst_s1_q};
  end

  // fault arrives from outside this clock domain
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      {fault_s1_q, fault_q} <= 2'b00;
    else
      {fault_s1_q, fault_q} <= {fault_active, fault_s1_q};
  end

  // id = function code shifted over the address
  function automatic logic [10:0] make_id(input logic [3:0] fc, input logic [6:0] addr);
    make_id = {fc, addr};
  endfunction

  logic cmd_hit;
  logic sync_hit;
  logic time_hit;
  logic hb_hit;
  logic running;
  logic comm_ok;
  logic cmd_fire;

  assign running  = (state_q == ST_PREOP) || (state_q == ST_OPER) || (state_q == ST_STOPPED);
  assign comm_ok  = (state_q == ST_PREOP) || (state_q == ST_OPER);
  assign cmd_hit  = rx_valid && running && rx_frame.id == `ID_NMT
                    && (rx_frame.data[15:8] == 8'h00 || rx_frame.data[14:8] == node_addr)
                    && rx_frame.data[15] == 1'b0;
  assign sync_hit = rx_valid && comm_ok && rx_frame.id == `ID_SYNC;
  assign time_hit = rx_valid && comm_ok && rx_frame.id == `ID_TIME;
  assign hb_hit   = rx_valid && rx_frame.id == make_id(`FC_HEARTBEAT, hb_producer_addr);
  // deferred command fires on sync; reset commands wait for the sync as well
  assign cmd_fire = cmd_pend_q && (!sync_mode || sync_hit);

  // latch latest command; in sync mode it waits for the next sync frame
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cmd_pend_q <= 1'b0;
      cmd_cs_q   <= 8'h00;
    end
    else if (cmd_hit)
    begin
      cmd_pend_q <= 1'b1;
      cmd_cs_q   <= rx_frame.data[7:0];
    end
    else if (cmd_fire || !running)
      cmd_pend_q <= 1'b0;
  end

  // state machine; commands are obeyed silently, nothing is sent back
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q    <= ST_INIT;
      step_cnt_q <= 16'h0000;
    end
    else
    begin
      case (state_q)
        ST_INIT, ST_RESET_APP, ST_RESET_COM:
        begin
          if (step_cnt_q >= 16'((state_q == ST_INIT) ? `INIT_CYCLES : `RST_STEP_CYCLES) - 16'h0001)
          begin
            step_cnt_q <= 16'h0000;
            case (state_q)
              ST_INIT:      state_q <= ST_RESET_APP;
              ST_RESET_APP: state_q <= ST_RESET_COM;
              default:      state_q <= ST_PREOP;
            endcase
          end
          else
            step_cnt_q <= step_cnt_q + 16'h0001;
        end
        ST_PREOP, ST_OPER, ST_STOPPED:
        begin
          if (cmd_fire)
          begin
            case (cmd_cs_q)
              `CS_START:      state_q <= ST_OPER;
              `CS_STOP:       state_q <= ST_STOPPED;
              `CS_PREOP:      state_q <= ST_PREOP;
              `CS_RESET_APP:  state_q <= ST_RESET_APP;
              `CS_RESET_COMM: state_q <= ST_RESET_COM;
              default:        state_q <= state_q;
            endcase
          end
        end
        default: state_q <= ST_INIT;
      endcase
    end
  end

  // boot-up owed once per arrival in pre-operational from a reset step
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      boot_pend_q <= 1'b0;
    else if (state_q == ST_RESET_COM && step_cnt_q >= 16'(`RST_STEP_CYCLES) - 16'h0001)
      boot_pend_q <= 1'b1;
    else if (tx_valid && tx_ready && tx_frame.id == make_id(`FC_HEARTBEAT, node_addr)
             && tx_frame.data[7:0] == `HB_STATE_BOOT)
      boot_pend_q <= 1'b0;
  end

  // heartbeat producer; period 0 disables production
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      hb_cnt_q  <= '0;
      hb_pend_q <= 1'b0;
    end
    else if (!running || hb_period == '0)
    begin
      hb_cnt_q  <= '0;
      hb_pend_q <= 1'b0;
    end
    else
    begin
      if (hb_cnt_q >= hb_period - 1'b1)
        hb_cnt_q <= '0;
      else
        hb_cnt_q <= hb_cnt_q + 1'b1;
      // a tick on the cycle the pending beat goes out is kept, not lost
      if (hb_cnt_q >= hb_period - 1'b1)
        hb_pend_q <= 1'b1;
      else if (tx_valid && tx_ready && tx_frame.id == make_id(`FC_HEARTBEAT, node_addr) && !boot_pend_q)
        hb_pend_q <= 1'b0;
    end
  end

  // heartbeat consumer; timeout 0 disables monitoring
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cons_cnt_q <= '0;
      hb_seen_q  <= 1'b0;
      hb_fault_q <= 1'b0;
    end
    else if (hb_timeout == '0)
    begin
      cons_cnt_q <= '0;
      hb_seen_q  <= 1'b0;
      hb_fault_q <= 1'b0;
    end
    else if (hb_hit)
    begin
      cons_cnt_q <= '0;
      hb_seen_q  <= 1'b1;
      hb_fault_q <= 1'b0;
    end
    else if (hb_seen_q)
    begin
      if (cons_cnt_q >= hb_timeout - 1'b1)
        hb_fault_q <= 1'b1;
      else
        cons_cnt_q <= cons_cnt_q + 1'b1;
    end
  end

  // emergency: one frame on fault entry, one code-0 frame on fault clearing
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      err_q        <= 1'b0;
      err_reg_q    <= `ERR_REG_NONE;
      emcy_code_q  <= `EMCY_CODE_CLEAR;
      emcy_pend_q  <= 1'b0;
      emcy_clear_q <= 1'b0;
    end
    else
    begin
      if (fault_q && !err_q)
      begin
        err_q       <= 1'b1;
        err_reg_q   <= fault_internal ? `ERR_REG_INTERNAL : `ERR_REG_GENERIC;
        emcy_code_q <= fault_code;
        emcy_pend_q <= 1'b1;
        emcy_clear_q <= 1'b0;
      end
      else if (!fault_q && err_q)
      begin
        err_q        <= 1'b0;
        err_reg_q    <= `ERR_REG_NONE;
        emcy_code_q  <= `EMCY_CODE_CLEAR;
        emcy_pend_q  <= 1'b1;
        emcy_clear_q <= 1'b1;
      end
      else if (tx_valid && tx_ready && tx_frame.id == make_id(`FC_EMCY, node_addr))
        emcy_pend_q <= 1'b0;
      else if (!comm_ok)
        emcy_pend_q <= 1'b0;
    end
  end

  // transmit arbitration: boot-up, then emergency, then heartbeat
  logic [7:0] hb_state_code;
  always_comb
  begin
    case (state_q)
      ST_OPER:    hb_state_code = `HB_STATE_OPER;
      ST_STOPPED: hb_state_code = `HB_STATE_STOPPED;
      ST_PREOP:   hb_state_code = `HB_STATE_PREOP;
      default:    hb_state_code = `HB_STATE_BOOT;
    endcase
  end

  can_frame_t tx_frame_d;
  logic       tx_valid_d;
  always_comb
  begin
    tx_valid_d = 1'b0;
    tx_frame_d = '0;
    if (boot_pend_q && state_q == ST_PREOP)
    begin
      tx_valid_d         = 1'b1;
      tx_frame_d.id      = make_id(`FC_HEARTBEAT, node_addr);
      tx_frame_d.len     = 4'h1;
      tx_frame_d.data[7:0] = `HB_STATE_BOOT;
    end
    else if (emcy_pend_q && comm_ok)
    begin
      tx_valid_d         = 1'b1;
      tx_frame_d.id      = make_id(`FC_EMCY, node_addr);
      tx_frame_d.len     = 4'h8;
      tx_frame_d.data    = {fault_maker, err_reg_q, emcy_code_q[15:8], emcy_code_q[7:0]};
    end
    else if (hb_pend_q)
    begin
      tx_valid_d         = 1'b1;
      tx_frame_d.id      = make_id(`FC_HEARTBEAT, node_addr);
      tx_frame_d.len     = 4'h1;
      tx_frame_d.data[7:0] = hb_state_code;
    end
  end

  // frame settles in flops first; valid waits a cycle for it and drops while the flops are stale
  can_frame_t tx_frame_q;
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      tx_frame_q <= '0;
    else
      tx_frame_q <= tx_frame_d;
  end
  assign tx_valid = tx_valid_d && (tx_frame_d == tx_frame_q);
  assign tx_frame = tx_frame_q;
  logic sync_q;
  logic time_q;
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      {sync_q, time_q} <= 2'b00;
    else
      {sync_q, time_q} <= {sync_hit, time_hit};
  end

  assign sync_pulse      = sync_q;
  assign time_pulse      = time_q;
  assign pdo_enable      = (state_q == ST_OPER);
  assign sdo_enable      = comm_ok;
  assign hb_fault        = hb_fault_q;
  assign error_reg       = err_reg_q;
  assign error_state     = err_q;
  assign node_state      = state_q;
  assign app_reset_pulse = (state_q == ST_RESET_APP) && (step_cnt_q == 16'h0000);

endmodule

`default_nettype wire

// File: rtl/nmt_node_pkg.sv
// types shared by the node-state logic and its bench
// no assumptions on surroundings
package nmt_node_pkg;

  typedef enum logic [2:0]
  {
    ST_INIT      = 3'b000,
    ST_RESET_APP = 3'b001,
    ST_RESET_COM = 3'b010,
    ST_PREOP     = 3'b011,
    ST_OPER      = 3'b100,
    ST_STOPPED   = 3'b101
  } node_state_t;

  typedef struct packed
  {
    logic [10:0] id;
    logic [3:0]  len;
    logic [63:0] data;
  } can_frame_t;

endpackage

// File: rtl/nmt_node_regs.svh
// timing counts, identifiers and code points for the node-state services
// included by the node top only; definitions only
`ifndef NMT_NODE_REGS_SVH
`define NMT_NODE_REGS_SVH

`define CLK_PERIOD_NS        10
`define INIT_TIME_NS         1000
`define INIT_CYCLES          ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_STEP_TIME_NS     100
`define RST_STEP_CYCLES      ((`RST_STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define FC_NMT               4'h0
`define FC_SYNC              4'h1
`define FC_TIME              4'h2
`define FC_EMCY              4'h1
`define FC_TPDO1             4'h3
`define FC_RPDO1             4'h4
`define FC_SDO_TX            4'hB
`define FC_SDO_RX            4'hC
`define FC_HEARTBEAT         4'hE
`define ID_NMT               11'h000
`define ID_SYNC              11'h080
`define ID_TIME              11'h100

`define CS_START             8'h01
`define CS_STOP              8'h02
`define CS_PREOP             8'h80
`define CS_RESET_APP         8'h81
`define CS_RESET_COMM        8'h82

`define ERR_REG_NONE         8'h00
`define ERR_REG_GENERIC      8'h01
`define ERR_REG_INTERNAL     8'h80
`define EMCY_CODE_CLEAR      16'h0000

`define HB_STATE_BOOT        8'h00
`define HB_STATE_STOPPED     8'h04
`define HB_STATE_OPER        8'h05
`define HB_STATE_PREOP       8'h7F

`endif

// File: verification/can_master_model.sv
// network master model: sends frames to the node, takes its transmit frames
// same clock as the node; ready and requests move at the falling edge, taken frames are counted at the rising edge
`timescale 1ns/1ps
`default_nettype none

module can_master_model
  import nmt_node_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       tx_valid,
  input  wire can_frame_t tx_frame,
  input  wire logic [3:0] stall,
  output logic            tx_ready,
  output logic            rx_valid,
  output can_frame_t      rx_frame,
  output can_frame_t      last_tx,
  output logic [7:0]      tx_count
);
  logic [3:0] wait_q;

  initial {tx_ready, rx_valid, rx_frame, last_tx, tx_count, wait_q} = '0;

  // stall cycles of ready low model a busy controller
  always @(negedge clock)
  begin
    if (tx_ready || !tx_valid)
      {tx_ready, wait_q} <= '0;
    else if (wait_q == stall)
      tx_ready <= 1'b1;
    else
      wait_q <= wait_q + 4'h1;
  end

  always @(posedge clock)
  begin
    if (tx_valid && tx_ready)
    begin
      last_tx <= tx_frame;
      tx_count <= tx_count + 8'h01;
    end
  end

  // one request at a time, unused bytes zeroed
  task automatic send(input logic [10:0] id, input logic [3:0] len, input logic [15:0] d);
    @(negedge clock);
    rx_frame <= {id, len, 48'h0, d};
    rx_valid <= 1'b1;
    @(negedge clock);
    rx_valid <= 1'b0;
    rx_frame <= ~rx_frame;  // released lines must not keep the old frame
  endtask
endmodule

`default_nettype wire

// File: verification/nmt_node_chk.sv
// port assertions for the node-state block
// bound into every nmt_node; one clock domain, reset_n low disables
`timescale 1ns/1ps
`default_nettype none

module nmt_node_chk
  import nmt_node_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic [6:0]  node_addr,
  input wire logic        rx_valid,
  input wire can_frame_t  rx_frame,
  input wire logic        sync_mode,
  input wire logic        tx_valid,
  input wire can_frame_t  tx_frame,
  input wire logic        sync_pulse,
  input wire logic        time_pulse,
  input wire logic        pdo_enable,
  input wire logic        sdo_enable,
  input wire logic [7:0]  error_reg,
  input wire logic        error_state,
  input wire node_state_t node_state,
  input wire logic        app_reset_pulse
);
  logic cmd;
  logic live;

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  // deferred commands are left to the bench, only immediate ones judged here
  assign cmd = rx_valid && rx_frame.id == 11'h000 && !sync_mode
               && (rx_frame.data[15:8] == 8'h00 || rx_frame.data[15:8] == {1'b0, node_addr})
               && node_state inside {ST_PREOP, ST_OPER, ST_STOPPED};
  assign live = node_state inside {ST_PREOP, ST_OPER};

  chk_start_cmd: assert property (cmd && rx_frame.data[7:0] == 8'h01 |-> ##2 node_state == ST_OPER)
    else $error("start command not obeyed");
  chk_stop_cmd: assert property (cmd && rx_frame.data[7:0] == 8'h02 |-> ##2 node_state == ST_STOPPED)
    else $error("stop command not obeyed");
  chk_preop_cmd: assert property (cmd && rx_frame.data[7:0] == 8'h80 |-> ##2 node_state == ST_PREOP)
    else $error("pre-operational command not obeyed");
  chk_app_reset: assert property (cmd && rx_frame.data[7:0] == 8'h81 |-> ##2 node_state == ST_RESET_APP
    && app_reset_pulse) else $error("application reset not entered");
  chk_app_step: assert property ($rose(node_state == ST_RESET_APP) |-> ##10 node_state == ST_RESET_COM)
    else $error("application reset step wrong length");
  chk_boot_frame: assert property ($rose(node_state == ST_PREOP) && $past(node_state) == ST_RESET_COM
    |-> ##[0:2] tx_valid && tx_frame.id == {4'hE, node_addr} && tx_frame.data[7:0] == 8'h00)
    else $error("boot-up frame missing");
  chk_pdo_gate: assert property (pdo_enable == (node_state == ST_OPER))
    else $error("process data enabled outside operational");
  chk_sdo_gate: assert property (sdo_enable == live)
    else $error("service data gating wrong");
  chk_sync_gate: assert property (rx_valid && rx_frame.id == 11'h080 |=> sync_pulse == $past(live))
    else $error("sync pulse gating wrong");
  chk_time_gate: assert property (rx_valid && rx_frame.id == 11'h100 |=> time_pulse == $past(live))
    else $error("time pulse gating wrong");
  chk_emcy_frame: assert property ($rose(error_state) && live |=> tx_valid
    && tx_frame.id == {4'h1, node_addr} && tx_frame.data[23:16] inside {8'h01, 8'h80})
    else $error("emergency frame wrong");
  chk_errreg_idle: assert property (!error_state |-> error_reg == 8'h00)
    else $error("error register set without fault");
endmodule

bind nmt_node nmt_node_chk nmt_node_chk_i (.clock, .reset_n, .node_addr, .rx_valid, .rx_frame, .sync_mode,
  .tx_valid, .tx_frame, .sync_pulse, .time_pulse, .pdo_enable, .sdo_enable, .error_reg, .error_state,
  .node_state, .app_reset_pulse);

`default_nettype wire

// File: verification/nmt_node_test.sv
// self-checking bench for the node-state block
// master model on the frame ports; stimulus on the falling edge
`timescale 1ns/1ps
`default_nettype none

module nmt_node_test;
  import nmt_node_pkg::*;
  logic        clock, reset_n, sync_mode, fault_active, fault_internal, rx_valid, tx_valid, tx_ready;
  logic        hb_fault, sync_pulse, time_pulse, pdo_enable, sdo_enable, error_state, app_reset_pulse;
  logic [6:0]  node_addr, hb_producer_addr;
  logic [15:0] hb_period, hb_timeout, fault_code;
  logic [39:0] fault_maker;
  logic [7:0]  error_reg, tx_count;
  logic [3:0]  stall;
  can_frame_t  rx_frame, tx_frame, last_tx;
  node_state_t node_state;
  int          failures, comparisons;

  nmt_node #(.HB_W(16)) nmt_node_i (.clock, .reset_n, .node_addr, .rx_valid, .rx_frame, .tx_valid, .tx_ready,
    .tx_frame, .hb_period, .hb_timeout, .hb_producer_addr, .hb_fault, .sync_mode, .sync_pulse, .time_pulse,
    .pdo_enable, .sdo_enable, .fault_active, .fault_code, .fault_internal, .fault_maker, .error_reg,
    .error_state, .node_state, .app_reset_pulse);
  can_master_model can_master_model_i (.clock, .tx_valid, .tx_frame, .stall, .tx_ready, .rx_valid, .rx_frame,
    .last_tx, .tx_count);

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input string what, input logic [78:0] seen, input logic [78:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      failures++;
    end
  endtask

  task automatic wrap_up();
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [78:0] fr(input logic [3:0] fc, input logic [3:0] len, input logic [63:0] d);
    return {fc, node_addr, len, d};
  endfunction

  task automatic wait_tx();
    logic [7:0] c;
    int n;
    c = tx_count;
    n = 0;
    while (tx_count === c && n < 300)
    begin
      @(negedge clock);
      n++;
    end
    check("tx count", tx_count, c + 8'h01);
  endtask

  task automatic cmd(input logic [7:0] cs, input logic [7:0] addr);
    can_master_model_i.send(11'h000, 4'h2, {addr, cs});
    repeat (2) @(negedge clock);
  endtask

  task automatic t_boot();
    wait_tx();
    check("boot frame", last_tx, fr(4'hE, 4'h1, 64'h0));
    check("boot state", node_state, ST_PREOP);
  endtask

  // a stray address and an unknown specifier must leave the state alone
  task automatic t_cmds();
    logic [7:0] cs[7] = '{8'h01, 8'h02, 8'h80, 8'h01, 8'h33, 8'h01, 8'h80};
    logic [7:0] ad[7] = '{8'h05, 8'h00, 8'h05, 8'h06, 8'h00, 8'h00, 8'h00};
    node_state_t st[7] = '{ST_OPER, ST_STOPPED, ST_PREOP, ST_PREOP, ST_PREOP, ST_OPER, ST_PREOP};
    logic [7:0] c;
    c = tx_count;
    foreach (cs[i])
    begin
      cmd(cs[i], ad[i]);
      check("cmd state", node_state, st[i]);
    end
    check("no reply", tx_count, c);
  endtask

  task automatic t_reset();
    cmd(8'h02, 8'h00);
    cmd(8'h81, 8'h05);
    check("app reset", node_state, ST_RESET_APP);
    wait_tx();
    check("boot again", last_tx, fr(4'hE, 4'h1, 64'h0));
    cmd(8'h82, 8'h00);
    check("comm reset", node_state, ST_RESET_COM);
    wait_tx();
    check("reset end", node_state, ST_PREOP);
  endtask

  task automatic t_sync();
    sync_mode = 1'b1;
    cmd(8'h02, 8'h00);
    check("deferred", node_state, ST_PREOP);
    // pulse stands only between the two edges after the frame
    can_master_model_i.send(11'h080, 4'h0, 16'h0000);
    check("sync pulse", sync_pulse, 1'b1);
    check("sync acts", node_state, ST_STOPPED);
    sync_mode = 1'b0;
    can_master_model_i.send(11'h080, 4'h0, 16'h0000);
    check("sync stopped", sync_pulse, 1'b0);
    cmd(8'h80, 8'h00);
    can_master_model_i.send(11'h100, 4'h0, 16'h0000);
    check("time pulse", time_pulse, 1'b1);
  endtask

  // second pass with a slow controller and an internal fault
  task automatic t_fault();
    for (int i = 0; i < 2; i++)
    begin
      stall = 4'(i * 3);
      fault_internal = i[0];
      fault_active = 1'b1;
      wait_tx();
      check("emcy set", last_tx, fr(4'h1, 4'h8, {fault_maker, i[0] ? 8'h80 : 8'h01, fault_code}));
      check("error state", error_state, 1'b1);
      fault_active = 1'b0;
      wait_tx();
      check("emcy clear", last_tx, fr(4'h1, 4'h8, {fault_maker, 24'h000000}));
      check("error reg", error_reg, 8'h00);
    end
    stall = 4'h0;
  endtask

  task automatic t_heart();
    cmd(8'h01, 8'h00);
    hb_period = 16'h0028;
    repeat (2)
    begin
      wait_tx();
      check("heartbeat", last_tx, fr(4'hE, 4'h1, 64'h05));
    end
    hb_period = 16'h0000;
    hb_timeout = 16'h001E;
    can_master_model_i.send(11'h711, 4'h1, 16'h0005);
    repeat (20) @(negedge clock);
    check("hb alive", hb_fault, 1'b0);
    repeat (20) @(negedge clock);
    check("hb lost", hb_fault, 1'b1);
    can_master_model_i.send(11'h711, 4'h1, 16'h0005);
    repeat (2) @(negedge clock);
    check("hb back", hb_fault, 1'b0);
  endtask

  initial
  begin
    {reset_n, sync_mode, fault_active, fault_internal, hb_period, hb_timeout, stall} = '0;
    node_addr = 7'h05;
    hb_producer_addr = 7'h11;
    fault_code = 16'h1234;
    fault_maker = 40'hA1B2C3D4E5;
    repeat (12) @(negedge clock);
    reset_n = 1'b1;
    t_boot();
    t_cmds();
    t_reset();
    t_sync();
    t_fault();
    t_heart();
    wrap_up();
  end

  // whole run needs well under 2000 cycles
  initial
  begin
    repeat (6000) @(posedge clock);
    failures++;
    wrap_up();
  end
endmodule

`default_nettype wire
